// ---- verilog/anpr_map.svh ----
// register offsets, field positions and reset values of the next page register set
`ifndef ANPR_MAP_SVH
`define ANPR_MAP_SVH
// printed register indices (byte address is four times the index)
`define ANPR_IDX_TX_LOW 16'h0208
`define ANPR_IDX_TX_MID 16'h0209
`define ANPR_IDX_TX_HIGH 16'h020A
`define ANPR_IDX_RX_LOW 16'h020B
`define ANPR_IDX_RX_MID 16'h020C
`define ANPR_IDX_RX_HIGH 16'h020D
// low word field positions
`define ANPR_BIT_MORE 15
`define ANPR_BIT_ACK 14
`define ANPR_BIT_ENC 13
`define ANPR_BIT_COMPLY 12
`define ANPR_BIT_TOGGLE 11
`define ANPR_CODE_MSB 10
// partner page slices holding the middle and high words
`define ANPR_MID_MSB 31
`define ANPR_MID_LSB 16
`define ANPR_HIGH_MSB 47
`define ANPR_HIGH_LSB 32
// bus response codes
`define ANPR_RESP_OKAY 2'h0
`define ANPR_RESP_SLVERR 2'h2
// reset values
`define ANPR_RST_TX_LOW 16'h2001
`define ANPR_RST_ZERO 16'h0000
// mask of software-writable bits in the transmit low word
`define ANPR_TX_LOW_WMASK 16'hB7FF
// message codes
`define ANPR_CODE_NULL 11'h001
`define ANPR_CODE_OUI 11'h005
`define ANPR_CODE_DEVID 11'h006
// bus answer latency in cycles for a read
`define ANPR_RD_WAIT 1
`endif

// ---- verilog/anpr_pkg.sv ----
// types shared by the next page register set
package anpr_pkg;
  typedef logic [15:0] anpr_word_t; // one 16-bit register word
  typedef logic [47:0] anpr_page_t; // one whole 48-bit page
  typedef enum logic [1:0] {ANPR_IDLE, ANPR_RD_ANS, ANPR_WR_ANS} anpr_bus_e; // bus slave phase
endpackage : anpr_pkg

// ---- verilog/anpr_hold_word.sv ----
// one holding register that latches a word on a capture strobe
`timescale 1ns/1ns
module anpr_hold_word #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // capture side
  input wire logic capture,
  input wire logic [WIDTH-1:0] live_word,
  // held value
  output logic [WIDTH-1:0] held_reg
);
  // elaboration check: an empty word cannot be held
  if (WIDTH < 1) begin : g_width_check
    $error("anpr_hold_word: WIDTH must be positive");
  end
  // latch on strobe, hold otherwise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      held_reg <= '0;
    end else if (capture) begin
      held_reg <= live_word;
    end
  end
endmodule : anpr_hold_word

// ---- verilog/anpr_regs.sv ----
// next page transmit and partner page receive registers on an avalon-mm slave
`timescale 1ns/1ns
`include "anpr_map.svh"
// Functional notes
// - reset loads null message page 0x2001
// - bit 15 read/write more pages request
// - bit 14 acknowledge, read-only, logic driven
// - bit 13 encoding select, resets to one
// - bit 12 read/write comply flag
// - bit 11 always reads zero
// - bits 10:0 read/write code, reset one
// - middle transmit word read/write, reset zero
// - high transmit word read/write, reset zero
// - low partner read latches middle, high
// - partner middle read returns latched value
// - partner low word read-only flags, encoding
// - partner bits 10:0 report code field
// - partner toggle at bit 11, reset zero
module anpr_regs #(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // autonegotiation reset, synchronous pulse from the arbitration machine
  input wire logic an_reset,
  // avalon-mm slave, word addressed by register index
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // arbitration machine side
  input wire logic tx_acknowledge_flag,
  input wire logic rx_page_valid,
  input wire anpr_pkg::anpr_page_t rx_page,
  output anpr_pkg::anpr_page_t tx_page_reg,
  output logic tx_page_commit_reg
);
  import anpr_pkg::*;

  // elaboration check: the register index needs sixteen address bits
  if (ADDR_W < 16) begin : g_addr_w_check
    $error("anpr_regs: ADDR_W must reach the 16-bit register index");
  end

  // software-held transmit words
  anpr_word_t next_page_tx_low_reg; // writable low word fields
  anpr_word_t next_page_tx_mid_reg; // first extra field
  anpr_word_t next_page_tx_high_reg; // second extra field
  // live partner page as delivered by the arbitration machine
  anpr_page_t partner_live_reg;
  // latched partner upper words
  anpr_word_t partner_page_rx_mid;
  anpr_word_t partner_page_rx_high;
  // bus slave state
  anpr_bus_e bus_reg;
  anpr_word_t rd_word; // decoded read word, combinational
  logic addr_hit; // address is a mapped register
  logic wr_take; // write accepted this cycle
  logic rd_take; // read accepted this cycle
  logic low_rd_capture; // partner low word read strobe
  logic [15:0] idx; // register index from the bus
  logic be_ok; // low two byte lanes both enabled
  anpr_word_t tx_low_view; // low word as software sees it

  assign idx = avs_address[15:0];
  assign be_ok = &avs_byteenable[1:0];
  // request is taken only in idle, so each request is answered exactly once
  assign wr_take = avs_write && (bus_reg == ANPR_IDLE);
  assign rd_take = avs_read && (bus_reg == ANPR_IDLE);
  assign low_rd_capture = rd_take && (idx == `ANPR_IDX_RX_LOW);

  // address decode of the six mapped words
  always_comb begin
    case (idx)
      `ANPR_IDX_TX_LOW, `ANPR_IDX_TX_MID, `ANPR_IDX_TX_HIGH,
      `ANPR_IDX_RX_LOW, `ANPR_IDX_RX_MID, `ANPR_IDX_RX_HIGH: begin
        addr_hit = 1'b1;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // low word view: ack from the logic, toggle forced to zero
  always_comb begin
    tx_low_view = next_page_tx_low_reg;
    tx_low_view[`ANPR_BIT_ACK] = tx_acknowledge_flag;
    tx_low_view[`ANPR_BIT_TOGGLE] = 1'b0;
  end

  // transmit low word; only writable bits stored, written as a whole word
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      next_page_tx_low_reg <= `ANPR_RST_TX_LOW;
    end else if (an_reset) begin
      next_page_tx_low_reg <= `ANPR_RST_TX_LOW;
    end else if (wr_take && be_ok && idx == `ANPR_IDX_TX_LOW) begin
      // request, encoding, comply and code stored; ack and toggle dropped
      next_page_tx_low_reg <= avs_writedata[15:0] & `ANPR_TX_LOW_WMASK;
    end
  end

  // transmit middle word
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      next_page_tx_mid_reg <= `ANPR_RST_ZERO;
    end else if (an_reset) begin
      next_page_tx_mid_reg <= `ANPR_RST_ZERO;
    end else if (wr_take && be_ok && idx == `ANPR_IDX_TX_MID) begin
      next_page_tx_mid_reg <= avs_writedata[15:0];
    end
  end

  // transmit high word
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      next_page_tx_high_reg <= `ANPR_RST_ZERO;
    end else if (an_reset) begin
      next_page_tx_high_reg <= `ANPR_RST_ZERO;
    end else if (wr_take && be_ok && idx == `ANPR_IDX_TX_HIGH) begin
      next_page_tx_high_reg <= avs_writedata[15:0];
    end
  end

  // committed page for the arbitration machine; upper words used as last written,
  // so writing them alone changes nothing the link sees
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_page_reg <= {`ANPR_RST_ZERO, `ANPR_RST_ZERO, `ANPR_RST_TX_LOW};
    end else if (an_reset) begin
      tx_page_reg <= {`ANPR_RST_ZERO, `ANPR_RST_ZERO, `ANPR_RST_TX_LOW};
    end else if (wr_take && be_ok && idx == `ANPR_IDX_TX_LOW) begin
      tx_page_reg <= {next_page_tx_high_reg, next_page_tx_mid_reg,
                      avs_writedata[15:0] & `ANPR_TX_LOW_WMASK};
    end
  end

  // one-cycle commit pulse alongside the new page
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_page_commit_reg <= 1'b0;
    end else begin
      tx_page_commit_reg <= wr_take && be_ok && !an_reset
                            && idx == `ANPR_IDX_TX_LOW;
    end
  end

  // live partner page, refreshed whenever a page arrives, unless an_reset clears it in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      partner_live_reg <= '0;
    end else if (an_reset) begin
      partner_live_reg <= '0;
    end else if (rx_page_valid) begin
      partner_live_reg <= rx_page;
    end
  end

  // latched partner middle word; captured with the low word read
  anpr_hold_word #(
    .WIDTH(16)
  ) u_hold_mid (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .capture(low_rd_capture),
    .live_word(partner_live_reg[`ANPR_MID_MSB:`ANPR_MID_LSB]),
    .held_reg(partner_page_rx_mid)
  );

  // latched partner high word
  anpr_hold_word #(
    .WIDTH(16)
  ) u_hold_high (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .capture(low_rd_capture),
    .live_word(partner_live_reg[`ANPR_HIGH_MSB:`ANPR_HIGH_LSB]),
    .held_reg(partner_page_rx_high)
  );

  // read mux; partner upper words come from the latches, not the live page
  always_comb begin
    case (idx)
      `ANPR_IDX_TX_LOW: begin
        rd_word = tx_low_view;
      end
      `ANPR_IDX_TX_MID: begin
        rd_word = next_page_tx_mid_reg;
      end
      `ANPR_IDX_TX_HIGH: begin
        rd_word = next_page_tx_high_reg;
      end
      `ANPR_IDX_RX_LOW: begin
        rd_word = partner_live_reg[15:0];
      end
      `ANPR_IDX_RX_MID: begin
        rd_word = partner_page_rx_mid;
      end
      `ANPR_IDX_RX_HIGH: begin
        rd_word = partner_page_rx_high;
      end
      default: begin
        rd_word = `ANPR_RST_ZERO;
      end
    endcase
  end

  // bus phase: one wait cycle, then answer with waitrequest low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_reg <= ANPR_IDLE;
    end else begin
      case (bus_reg)
        ANPR_IDLE: begin
          if (rd_take) begin
            bus_reg <= ANPR_RD_ANS;
          end else if (wr_take) begin
            bus_reg <= ANPR_WR_ANS;
          end
        end
        ANPR_RD_ANS, ANPR_WR_ANS: begin
          bus_reg <= ANPR_IDLE;
        end
        default: begin
          bus_reg <= ANPR_IDLE;
        end
      endcase
    end
  end

  // waitrequest: low only in the answer cycle; high from reset so no edge is missed
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(rd_take || wr_take);
    end
  end

  // read data registered with the request; stands while waitrequest is low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= '0;
    end else if (rd_take) begin
      avs_readdata <= {16'h0000, rd_word};
    end
  end

  // response: slave error for an unmapped index, okay otherwise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_response <= `ANPR_RESP_OKAY;
    end else if (rd_take || wr_take) begin
      avs_response <= addr_hit ? `ANPR_RESP_OKAY : `ANPR_RESP_SLVERR;
    end
  end

  // helper: a partner low read was taken one cycle ago
  logic low_rd_seen_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_rd_seen_reg <= 1'b0;
    end else begin
      low_rd_seen_reg <= low_rd_capture;
    end
  end

  sequence s_low_write;
    wr_take && be_ok && !an_reset && idx == `ANPR_IDX_TX_LOW;
  endsequence

  chk_reset_page: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    an_reset |=> tx_page_reg == {`ANPR_RST_ZERO, `ANPR_RST_ZERO, `ANPR_RST_TX_LOW})
    else $error("page not reset to null message");

  chk_commit_page: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_low_write |=> tx_page_commit_reg && tx_page_reg[47:16] ==
      {$past(next_page_tx_high_reg), $past(next_page_tx_mid_reg)})
    else $error("commit did not carry upper words");

  chk_more_flag: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_low_write |=> tx_page_reg[`ANPR_BIT_MORE] == $past(avs_writedata[`ANPR_BIT_MORE]))
    else $error("request flag not stored");

  chk_toggle_zero: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (rd_take && idx == `ANPR_IDX_TX_LOW) |=> avs_readdata[`ANPR_BIT_TOGGLE] == 1'b0)
    else $error("transmit toggle read nonzero");

  chk_ack_drive: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (rd_take && idx == `ANPR_IDX_TX_LOW) |=>
      avs_readdata[`ANPR_BIT_ACK] == $past(tx_acknowledge_flag))
    else $error("ack not from negotiation logic");

  chk_mid_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (wr_take && be_ok && !an_reset && idx == `ANPR_IDX_TX_MID) |=>
      next_page_tx_mid_reg == $past(avs_writedata[15:0]))
    else $error("middle word not written");

  chk_low_latch: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    low_rd_seen_reg |->
      partner_page_rx_mid == $past(partner_live_reg[`ANPR_MID_MSB:`ANPR_MID_LSB]))
    else $error("middle word not latched on low read");

  chk_mid_held: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !low_rd_capture |=> $stable(partner_page_rx_mid))
    else $error("latched word changed without low read");

  chk_rx_toggle: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (rd_take && idx == `ANPR_IDX_RX_LOW) |=>
      avs_readdata[`ANPR_BIT_TOGGLE] == $past(partner_live_reg[`ANPR_BIT_TOGGLE]))
    else $error("partner toggle not reported");

  chk_high_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (wr_take && be_ok && !an_reset && idx == `ANPR_IDX_TX_HIGH) |=>
      next_page_tx_high_reg == $past(avs_writedata[15:0]))
    else $error("high word not written");

  chk_enc_reset: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    an_reset |=> next_page_tx_low_reg[`ANPR_BIT_ENC])
    else $error("encoding select not reset to message page");

  chk_rx_code: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (rd_take && idx == `ANPR_IDX_RX_LOW) |=>
      avs_readdata[`ANPR_CODE_MSB:0] == $past(partner_live_reg[`ANPR_CODE_MSB:0]))
    else $error("partner code field not reported");

  chk_bus_answer: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (rd_take || wr_take) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");
endmodule : anpr_regs

// ---- tb/anpr_arb_model.sv ----
// behavioural arbitration machine that feeds partner pages and the acknowledge level
`timescale 1ns/1ns
module anpr_arb_model import anpr_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // bench commands
  input wire logic send,
  input wire anpr_pkg::anpr_page_t send_page,
  input wire logic ack_level,
  // towards the register set
  output logic tx_acknowledge_flag,
  output logic rx_page_valid,
  output anpr_pkg::anpr_page_t rx_page
);
  // acknowledge follows the bench level one cycle late, like a registered state bit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_acknowledge_flag <= 1'b0;
    end else begin
      tx_acknowledge_flag <= ack_level;
    end
  end
  // page shown for one valid cycle, then garbled so a late capture is caught
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_page_valid <= 1'b0;
      rx_page <= 48'h0;
    end else if (send) begin
      rx_page_valid <= 1'b1;
      rx_page <= send_page;
    end else begin
      rx_page_valid <= 1'b0;
      rx_page <= ~rx_page;
    end
  end
endmodule : anpr_arb_model

// ---- tb/testbench.sv ----
// self-checking bench for the next page register set
`timescale 1ns/1ns
`include "anpr_map.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin num_errors++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module testbench;
  import anpr_pkg::*;
  logic core_clk, rst_n, an_reset; // clock and resets
  logic [15:0] avs_address; // avalon request
  logic avs_read, avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata; // avalon answer
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic tx_acknowledge_flag, rx_page_valid, tx_page_commit_reg; // arbitration side
  anpr_page_t rx_page, tx_page_reg, send_page, p1, p2;
  logic send, ack_level, cmt; // model commands, captured commit
  logic [31:0] rd; // captured read data
  logic [1:0] rsp; // captured response
  anpr_word_t seed, w_lo, w_mid, w_hi;
  int num_errors, n_checks, cycles;
  anpr_regs #(.ADDR_W(16)) dut (.core_clk(core_clk), .rst_n(rst_n), .an_reset(an_reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .tx_acknowledge_flag(tx_acknowledge_flag),
    .rx_page_valid(rx_page_valid), .rx_page(rx_page), .tx_page_reg(tx_page_reg),
    .tx_page_commit_reg(tx_page_commit_reg));
  anpr_arb_model arb (.core_clk(core_clk), .rst_n(rst_n), .send(send),
    .send_page(send_page), .ack_level(ack_level), .tx_acknowledge_flag(tx_acknowledge_flag),
    .rx_page_valid(rx_page_valid), .rx_page(rx_page));
  // 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_sim();
    end
  end
  // pseudo-random words
  function automatic anpr_word_t lfsr_next(input anpr_word_t s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  // expected read of the transmit low word: ack live at 14, toggle always zero
  function automatic anpr_word_t exp_low(input anpr_word_t w, input logic ack);
    anpr_word_t r;
    r = w & 16'hB7FF;
    r[14] = ack;
    return r;
  endfunction : exp_low
  // one avalon transfer, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [15:0] adr, input anpr_word_t wd,
                     input logic [3:0] be);
    @(posedge core_clk);
    avs_address <= adr;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {16'h0000, wd};
    avs_byteenable <= be;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rsp = avs_response;
    cmt = tx_page_commit_reg;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // read a register and compare the whole bus word
  task automatic rd_chk(input string nm, input logic [15:0] adr, input anpr_word_t ex);
    bus(1'b0, adr, 16'h0000, 4'hF);
    `CHK(nm, {16'h0000, ex}, rd)
  endtask : rd_chk
  // hand one page to the model and let it land in the live partner page
  task automatic send_pg(input anpr_page_t p);
    @(posedge core_clk);
    send <= 1'b1;
    send_page <= p;
    @(posedge core_clk);
    send <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : send_pg
  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    rst_n = 1'b0;
    an_reset = 1'b0;
    avs_address = 16'h0000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    send = 1'b0;
    send_page = 48'h0;
    ack_level = 1'b0;
    seed = 16'h0062;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    // reset contents
    rd_chk("tx low reset", `ANPR_IDX_TX_LOW, `ANPR_RST_TX_LOW);
    rd_chk("tx mid reset", `ANPR_IDX_TX_MID, `ANPR_RST_ZERO);
    rd_chk("tx high reset", `ANPR_IDX_TX_HIGH, `ANPR_RST_ZERO);
    rd_chk("rx low reset", `ANPR_IDX_RX_LOW, `ANPR_RST_ZERO);
    rd_chk("rx mid reset", `ANPR_IDX_RX_MID, `ANPR_RST_ZERO);
    `CHK("tx page reset", 48'h000000002001, tx_page_reg)
    // random pages, first three carry every message code
    for (int i = 0; i < 8; i++) begin
      seed = lfsr_next(seed);
      w_mid = seed;
      seed = lfsr_next(seed);
      w_hi = seed;
      seed = lfsr_next(seed);
      w_lo = seed;
      if (i < 3) begin
        w_lo[13] = 1'b1;
        w_lo[10:0] = (i == 0) ? `ANPR_CODE_NULL : (i == 1) ? `ANPR_CODE_OUI : `ANPR_CODE_DEVID;
      end
      ack_level <= w_hi[0];
      bus(1'b1, `ANPR_IDX_TX_MID, w_mid, 4'hF);
      `CHK("mid write resp", `ANPR_RESP_OKAY, rsp)
      `CHK("mid no commit", 1'b0, cmt)
      bus(1'b1, `ANPR_IDX_TX_HIGH, w_hi, 4'hF);
      bus(1'b1, `ANPR_IDX_TX_LOW, w_lo, 4'hF);
      `CHK("commit pulse", 1'b1, cmt)
      `CHK("tx page", {w_hi, w_mid, w_lo & 16'hB7FF}, tx_page_reg)
      rd_chk("tx low", `ANPR_IDX_TX_LOW, exp_low(w_lo, w_hi[0]));
      rd_chk("tx mid", `ANPR_IDX_TX_MID, w_mid);
      rd_chk("tx high", `ANPR_IDX_TX_HIGH, w_hi);
    end
    // partial byte enables leave the word alone
    bus(1'b1, `ANPR_IDX_TX_MID, ~w_mid, 4'h1);
    rd_chk("tx mid be", `ANPR_IDX_TX_MID, w_mid);
    // partner page latching across a newer arrival
    seed = lfsr_next(seed);
    p1 = {seed, ~seed, seed ^ 16'h0800};
    p1[11] = 1'b1;
    seed = lfsr_next(seed);
    p2 = {~seed, seed, seed};
    send_pg(p1);
    rd_chk("rx low", `ANPR_IDX_RX_LOW, p1[15:0]);
    send_pg(p2);
    rd_chk("rx mid held", `ANPR_IDX_RX_MID, p1[31:16]);
    rd_chk("rx high held", `ANPR_IDX_RX_HIGH, p1[47:32]);
    bus(1'b1, `ANPR_IDX_RX_LOW, 16'hFFFF, 4'hF);
    rd_chk("rx low ro", `ANPR_IDX_RX_LOW, p2[15:0]);
    rd_chk("rx mid new", `ANPR_IDX_RX_MID, p2[31:16]);
    // unmapped index answers with an error code
    bus(1'b0, 16'h0300, 16'h0000, 4'hF);
    `CHK("unmapped resp", `ANPR_RESP_SLVERR, rsp)
    `CHK("unmapped data", 32'h0, rd)
    // autonegotiation reset reloads the null message page
    @(posedge core_clk);
    an_reset <= 1'b1;
    @(posedge core_clk);
    an_reset <= 1'b0;
    rd_chk("tx low anrst", `ANPR_IDX_TX_LOW, exp_low(`ANPR_RST_TX_LOW, w_hi[0]));
    rd_chk("tx high anrst", `ANPR_IDX_TX_HIGH, `ANPR_RST_ZERO);
    `CHK("tx page anrst", 48'h000000002001, tx_page_reg)
    rd_chk("rx low anrst", `ANPR_IDX_RX_LOW, `ANPR_RST_ZERO);
    end_sim();
  end
endmodule : testbench
